// ### rtl/occd_pkg.sv
// constants shared by the output channel clock divider files
package occd_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int DRV_N = 3;
	localparam int CNT_W = 6;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [9:0] OFS_DIV2_DCC = 10'h098;
	localparam logic [9:0] OFS_DIV3_CNT = 10'h099;
	localparam logic [9:0] OFS_DIV3_CTL = 10'h09A;
	localparam logic [9:0] OFS_CH3_PD = 10'h09B;
	localparam logic [9:0] OFS_STATIC = 10'h09C;
	localparam logic [9:0] OFS_STATUS = 10'h09D;
	localparam logic [9:0] OFS_DIV2_CNT = 10'h196;
	localparam logic [9:0] OFS_DIV2_CTL = 10'h197;
	localparam logic [9:0] OFS_CH2_PD = 10'h198;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int BIT_PD = 2;
	localparam int BIT_DCC_DIS = 0;
	localparam int BIT_BYPASS = 7;
	localparam int BIT_IGN_SYNC = 6;
	localparam int BIT_FORCE_HI = 5;
	localparam int BIT_START_HI = 4;
	localparam int LOW_MSB = 7;
	localparam int LOW_LSB = 4;
	localparam int HIGH_MSB = 3;
	localparam int HIGH_LSB = 0;
	localparam int PHASE_MSB = 3;
	localparam int PHASE_LSB = 0;

	// ************************************************************
	// values after reset
	// ************************************************************
	localparam logic [7:0] RST_DIV2_CNT = 8'h11;
	localparam logic [7:0] RST_DIV3_CNT = 8'h00;
	localparam logic [7:0] RST_CTL = 8'h00;
	localparam logic RST_BIT = 1'b0;
	localparam logic [1:0] RST_STATIC = 2'h0;
	localparam logic [5:0] RST_CNT = 6'h00;
endpackage

// ### rtl/occd_drivers.sv
// three output driver pairs of one channel with high-impedance power-down
`timescale 1ns/1ns
module occd_drivers (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_level,
	input wire logic i_power_down,
	output logic [2:0] o_data,
	output logic [2:0] o_oe
);
	genvar g;
	generate
		for (g = 0; g < occd_pkg::DRV_N; g++)
		begin : g_drv
			always_ff @(posedge i_clock or posedge i_rst)
			begin
				if (i_rst)
				begin
					o_data[g] <= 1'b0;
					o_oe[g] <= 1'b0;
				end
				else
				begin
					// powered-down pairs float and hold a quiet data level
					o_data[g] <= i_level & ~i_power_down;
					o_oe[g] <= ~i_power_down;
				end
			end
		end
	endgenerate
endmodule // occd_drivers

// ### rtl/occd_divider.sv
// one integer output divider: counts, bypass, sync, phase, forced level
`timescale 1ns/1ns
module occd_divider (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_in_level,
	input wire logic i_in_rise,
	input wire logic i_sync,
	input wire logic [7:0] i_counts,
	input wire logic [7:0] i_ctl,
	input wire logic i_dcc_dis,
	input wire logic i_static,
	output logic o_level
);
	logic [5:0] total, hi_len, lo_len, cnt_q;
	logic sync_act, bypass, force_hi, start_hi, run, toggle;
	logic [3:0] phase;

	assign bypass = i_ctl[occd_pkg::BIT_BYPASS];
	assign force_hi = i_ctl[occd_pkg::BIT_FORCE_HI];
	assign start_hi = i_ctl[occd_pkg::BIT_START_HI];
	assign phase = i_ctl[occd_pkg::PHASE_MSB:occd_pkg::PHASE_LSB];
	assign sync_act = i_sync & ~i_ctl[occd_pkg::BIT_IGN_SYNC];
	assign total = 6'(i_counts[occd_pkg::LOW_MSB:occd_pkg::LOW_LSB])
		+ 6'(i_counts[occd_pkg::HIGH_MSB:occd_pkg::HIGH_LSB]) + 6'h02;

	always_comb
	begin
		if (i_dcc_dis)
		begin
			hi_len = 6'(i_counts[occd_pkg::HIGH_MSB:occd_pkg::HIGH_LSB]) + 6'h01;
			lo_len = 6'(i_counts[occd_pkg::LOW_MSB:occd_pkg::LOW_LSB]) + 6'h01;
		end
		else
		begin
			// correction keeps the period and splits it evenly, odd cycle high
			hi_len = 6'((total + 6'h01) >> 1);
			lo_len = total >> 1;
		end
	end

	assign run = ~sync_act & ~i_static & ~bypass;
	assign toggle = run & i_in_rise & (cnt_q == 6'h00);

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_level <= 1'b0;
			cnt_q <= occd_pkg::RST_CNT;
		end
		else if (sync_act)
		begin
			o_level <= start_hi;
			cnt_q <= 6'(phase) + (start_hi ? hi_len : lo_len) - 6'h01;
		end
		else if (i_static)
			o_level <= force_hi;
		else if (bypass)
			o_level <= i_in_level;
		else if (toggle)
		begin
			o_level <= ~o_level;
			cnt_q <= (o_level ? lo_len : hi_len) - 6'h01;
		end
		else if (run & i_in_rise)
			cnt_q <= cnt_q - 6'h01;
	end

	// ************************************************************
	// checks
	// ************************************************************
	logic [5:0] seg_q;
	logic first_q, dirty_q;
	logic [16:0] cfg_q;
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			seg_q <= occd_pkg::RST_CNT;
			first_q <= 1'b1;
			dirty_q <= 1'b1;
			cfg_q <= 17'h00000;
		end
		else
		begin
			cfg_q <= {i_counts, i_ctl, i_dcc_dis};
			seg_q <= (sync_act | toggle) ? 6'h00 : seg_q + 6'(run & i_in_rise);
			first_q <= sync_act | (first_q & ~toggle);
			dirty_q <= ~sync_act & ((dirty_q & ~toggle) | ~run
				| (cfg_q != {i_counts, i_ctl, i_dcc_dis}));
		end
	end

	seg_len_a: assert property (@(posedge i_clock) disable iff (i_rst)
		// a setting that changes at this edge has not reached dirty_q yet
		(toggle && !first_q && !dirty_q && cfg_q == {i_counts, i_ctl, i_dcc_dis})
		|-> (seg_q + 6'h01 == (o_level ? hi_len : lo_len)))
		else $error("divider level length wrong");
	phase_delay_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(toggle && first_q && !dirty_q && cfg_q == {i_counts, i_ctl, i_dcc_dis})
		|-> (seg_q + 6'h01 == 6'(phase) + (o_level ? hi_len : lo_len)))
		else $error("first edge after sync not delayed by phase");
	bypass_follow_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(!sync_act && !i_static && bypass) |=> (o_level == $past(i_in_level)))
		else $error("bypass does not follow input");
	forced_level_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(!sync_act && i_static) |=> (o_level == $past(force_hi)))
		else $error("static level differs from force bit");
	sync_start_a: assert property (@(posedge i_clock) disable iff (i_rst)
		sync_act |=> (o_level == $past(start_hi)) ##1 1'b1)
		else $error("sync does not restart at start level");
	ignore_sync_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_sync && i_ctl[occd_pkg::BIT_IGN_SYNC] && run && !i_in_rise) |=> $stable(o_level))
		else $error("ignored sync moved output");
	dcc_split_a: assert property (@(posedge i_clock) disable iff (i_rst)
		!i_dcc_dis |-> (hi_len + lo_len == total) && (hi_len - lo_len <= 6'h01))
		else $error("corrected duty split uneven");
endmodule // occd_divider

// ### rtl/occd_top.sv
// output channel clock divider block: registers, dividers 2 and 3, drivers
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
module occd_top (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [9:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_div_in,
	input wire logic i_sync,
	output logic [7:0] o_rdata,
	output logic [2:0] o_ch2_data,
	output logic [2:0] o_ch2_oe,
	output logic [2:0] o_ch3_data,
	output logic [2:0] o_ch3_oe
);
	// ************************************************************
	// register storage
	// ************************************************************
	logic [7:0] div2_cnt_q;
	logic [7:0] div2_ctl_q;
	logic [7:0] div3_cnt_q;
	logic [7:0] div3_ctl_q;
	logic pd2_q;
	logic pd3_q;
	logic dcc2_dis_q;
	logic dcc3_dis_q;
	logic [1:0] static_q;
	logic div_in_q;
	logic div_rise;
	logic lvl2;
	logic lvl3;
	logic [7:0] rdata_d;

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			div2_cnt_q <= occd_pkg::RST_DIV2_CNT;
		else if (i_wr && i_addr == occd_pkg::OFS_DIV2_CNT)
			div2_cnt_q <= i_wdata;
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			div2_ctl_q <= occd_pkg::RST_CTL;
		else if (i_wr && i_addr == occd_pkg::OFS_DIV2_CTL)
			div2_ctl_q <= i_wdata;
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			div3_cnt_q <= occd_pkg::RST_DIV3_CNT;
		else if (i_wr && i_addr == occd_pkg::OFS_DIV3_CNT)
			div3_cnt_q <= i_wdata;
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			div3_ctl_q <= occd_pkg::RST_CTL;
		else if (i_wr && i_addr == occd_pkg::OFS_DIV3_CTL)
			div3_ctl_q <= i_wdata;
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			pd2_q <= occd_pkg::RST_BIT;
		else if (i_wr && i_addr == occd_pkg::OFS_CH2_PD)
			pd2_q <= i_wdata[occd_pkg::BIT_PD];
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			pd3_q <= occd_pkg::RST_BIT;
			dcc3_dis_q <= occd_pkg::RST_BIT;
		end
		else if (i_wr && i_addr == occd_pkg::OFS_CH3_PD)
		begin
			pd3_q <= i_wdata[occd_pkg::BIT_PD];
			dcc3_dis_q <= i_wdata[occd_pkg::BIT_DCC_DIS];
		end
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			dcc2_dis_q <= occd_pkg::RST_BIT;
		else if (i_wr && i_addr == occd_pkg::OFS_DIV2_DCC)
			dcc2_dis_q <= i_wdata[occd_pkg::BIT_DCC_DIS];
	end

	// static hold must be paired with ignore-sync by software, or sync wins
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			static_q <= occd_pkg::RST_STATIC;
		else if (i_wr && i_addr == occd_pkg::OFS_STATIC)
			static_q <= i_wdata[1:0];
	end

	// ************************************************************
	// read port
	// ************************************************************
	always_comb
	begin
		rdata_d = 8'h00;
		if (i_addr == occd_pkg::OFS_DIV2_CNT)
			rdata_d = div2_cnt_q;
		else if (i_addr == occd_pkg::OFS_DIV2_CTL)
			rdata_d = div2_ctl_q;
		else if (i_addr == occd_pkg::OFS_DIV3_CNT)
			rdata_d = div3_cnt_q;
		else if (i_addr == occd_pkg::OFS_DIV3_CTL)
			rdata_d = div3_ctl_q;
		else if (i_addr == occd_pkg::OFS_CH2_PD)
			rdata_d[occd_pkg::BIT_PD] = pd2_q;
		else if (i_addr == occd_pkg::OFS_CH3_PD)
		begin
			rdata_d[occd_pkg::BIT_PD] = pd3_q;
			rdata_d[occd_pkg::BIT_DCC_DIS] = dcc3_dis_q;
		end
		else if (i_addr == occd_pkg::OFS_DIV2_DCC)
			rdata_d[occd_pkg::BIT_DCC_DIS] = dcc2_dis_q;
		else if (i_addr == occd_pkg::OFS_STATIC)
			rdata_d[1:0] = static_q;
		else if (i_addr == occd_pkg::OFS_STATUS)
			rdata_d[3:0] = {i_sync, div_in_q, lvl3, lvl2};
	end

	// unmapped reads return zero; data stands only in the cycle after the strobe
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			o_rdata <= 8'h00;
		else if (i_rd)
			o_rdata <= rdata_d;
		else
			o_rdata <= 8'h00;
	end

	// ************************************************************
	// divider input edge
	// ************************************************************
	// the divider input is sampled on the system clock, so it must run
	// at no more than half the clock rate for every edge to count
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			div_in_q <= 1'b0;
		else
			div_in_q <= i_div_in;
	end

	assign div_rise = i_div_in & ~div_in_q;

	// ************************************************************
	// dividers
	// ************************************************************
	occd_divider u_div2 (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_in_level(i_div_in),
		.i_in_rise(div_rise),
		.i_sync(i_sync),
		.i_counts(div2_cnt_q),
		.i_ctl(div2_ctl_q),
		.i_dcc_dis(dcc2_dis_q),
		.i_static(static_q[0]),
		.o_level(lvl2)
	);

	occd_divider u_div3 (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_in_level(i_div_in),
		.i_in_rise(div_rise),
		.i_sync(i_sync),
		.i_counts(div3_cnt_q),
		.i_ctl(div3_ctl_q),
		.i_dcc_dis(dcc3_dis_q),
		.i_static(static_q[1]),
		.o_level(lvl3)
	);

	// ************************************************************
	// output drivers
	// ************************************************************
	occd_drivers u_drv2 (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_level(lvl2),
		.i_power_down(pd2_q),
		.o_data(o_ch2_data),
		.o_oe(o_ch2_oe)
	);

	occd_drivers u_drv3 (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_level(lvl3),
		.i_power_down(pd3_q),
		.o_data(o_ch3_data),
		.o_oe(o_ch3_oe)
	);

	// ************************************************************
	// checks
	// ************************************************************
	ch2_hiz_a: assert property (@(posedge i_clock) disable iff (i_rst)
		pd2_q |=> (o_ch2_oe == 3'h0) && (o_ch2_data == 3'h0))
		else $error("channel 2 drives while powered down");
	ch3_hiz_a: assert property (@(posedge i_clock) disable iff (i_rst)
		pd3_q |=> (o_ch3_oe == 3'h0) && (o_ch3_data == 3'h0))
		else $error("channel 3 drives while powered down");
	ch2_drive_a: assert property (@(posedge i_clock) disable iff (i_rst)
		!pd2_q |=> (o_ch2_oe == 3'h7) && (o_ch2_data == {3{$past(lvl2)}}))
		else $error("channel 2 not driving divider level");
	ch3_drive_a: assert property (@(posedge i_clock) disable iff (i_rst)
		!pd3_q |=> (o_ch3_oe == 3'h7) && (o_ch3_data == {3{$past(lvl3)}}))
		else $error("channel 3 not driving divider level");
	pd_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_wr && i_addr == occd_pkg::OFS_CH2_PD && i_wdata[occd_pkg::BIT_PD])
		|=> ##1 (o_ch2_oe == 3'h0))
		else $error("channel 2 power-down write not honoured in two cycles");
	pd3_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_wr && i_addr == occd_pkg::OFS_CH3_PD && i_wdata[occd_pkg::BIT_PD])
		|=> ##1 (o_ch3_oe == 3'h0))
		else $error("channel 3 power-down write not honoured in two cycles");

	// ************************************************************
	// register and pin checks
	// ************************************************************
	dcc2_store_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_wr && i_addr == occd_pkg::OFS_DIV2_DCC)
		|=> (dcc2_dis_q == $past(i_wdata[occd_pkg::BIT_DCC_DIS])))
		else $error("divider 2 correction bit not stored");
	dcc3_store_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_wr && i_addr == occd_pkg::OFS_CH3_PD)
		|=> (dcc3_dis_q == $past(i_wdata[occd_pkg::BIT_DCC_DIS])))
		else $error("divider 3 correction bit not stored");
	cnt3_store_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_wr && i_addr == occd_pkg::OFS_DIV3_CNT)
		|=> (div3_cnt_q == $past(i_wdata)))
		else $error("divider 3 counts not stored");
	ctl3_store_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_wr && i_addr == occd_pkg::OFS_DIV3_CTL)
		|=> (div3_ctl_q == $past(i_wdata)))
		else $error("divider 3 control not stored");
	ctl2_store_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_wr && i_addr == occd_pkg::OFS_DIV2_CTL)
		|=> (div2_ctl_q == $past(i_wdata)))
		else $error("divider 2 control not stored");
	cnt3_read_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_rd && i_addr == occd_pkg::OFS_DIV3_CNT)
		|=> (o_rdata == $past(div3_cnt_q)))
		else $error("divider 3 counts read back wrong");
	ctl3_read_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_rd && i_addr == occd_pkg::OFS_DIV3_CTL)
		|=> (o_rdata == $past(div3_ctl_q)))
		else $error("divider 3 control read back wrong");
	ctl2_read_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_rd && i_addr == occd_pkg::OFS_DIV2_CTL)
		|=> (o_rdata == $past(div2_ctl_q)))
		else $error("divider 2 control read back wrong");
	ch2_force_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(static_q[0] && div2_ctl_q[occd_pkg::BIT_IGN_SYNC]) |=> ##1 (o_ch2_data
		== ($past(pd2_q) ? 3'h0 : {3{$past(div2_ctl_q[occd_pkg::BIT_FORCE_HI], 2)}})))
		else $error("channel 2 not holding forced level");
	ch3_force_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(static_q[1] && div3_ctl_q[occd_pkg::BIT_IGN_SYNC]) |=> ##1 (o_ch3_data
		== ($past(pd3_q) ? 3'h0 : {3{$past(div3_ctl_q[occd_pkg::BIT_FORCE_HI], 2)}})))
		else $error("channel 3 not holding forced level");
	ch2_bypass_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(div2_ctl_q[occd_pkg::BIT_BYPASS] && !static_q[0]
		&& !(i_sync && !div2_ctl_q[occd_pkg::BIT_IGN_SYNC]))
		|=> ##1 (o_ch2_data == ($past(pd2_q) ? 3'h0 : {3{$past(i_div_in, 2)}})))
		else $error("channel 2 bypass does not pass the input clock");
	ch3_bypass_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(div3_ctl_q[occd_pkg::BIT_BYPASS] && !static_q[1]
		&& !(i_sync && !div3_ctl_q[occd_pkg::BIT_IGN_SYNC]))
		|=> ##1 (o_ch3_data == ($past(pd3_q) ? 3'h0 : {3{$past(i_div_in, 2)}})))
		else $error("channel 3 bypass does not pass the input clock");
endmodule // occd_top

// ### bench/occd_rx_model.sv
// receiver model on one driver pair: measures the run lengths of the clock it sees
`timescale 1ns/1ns
module occd_rx_model (
	input wire logic i_clock,
	input wire logic i_data,
	input wire logic i_oe,
	output logic [15:0] o_hi_run,
	output logic [15:0] o_lo_run,
	output logic [15:0] o_edges
);
	logic lvl_q = 1'b0;
	logic [15:0] run_q = 16'h0000;
	logic [15:0] hi_q = 16'h0000;
	logic [15:0] lo_q = 16'h0000;
	logic [15:0] ed_q = 16'h0000;
	logic pin;

	assign o_hi_run = hi_q;
	assign o_lo_run = lo_q;
	assign o_edges = ed_q;

	// a floating pair carries no level; the inverse keeps a stale value from passing
	assign pin = i_oe ? i_data : ~lvl_q;

	always @(posedge i_clock)
	begin
		if (pin === lvl_q)
			run_q <= run_q + 16'h0001;
		else if (i_oe)
		begin
			if (lvl_q)
				hi_q <= run_q;
			else
				lo_q <= run_q;
			ed_q <= ed_q + 16'h0001;
			run_q <= 16'h0001;
		end
		lvl_q <= pin;
	end
endmodule // occd_rx_model

// ### bench/occd_top_tb.sv
// self-checking bench for the output channel clock divider block
`timescale 1ns/1ns
module occd_top_tb;
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic [9:0] i_addr = 10'h000;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_div_in = 1'b0;
	logic i_sync = 1'b0;
	logic [7:0] o_rdata;
	logic [2:0] o_ch2_data;
	logic [2:0] o_ch2_oe;
	logic [2:0] o_ch3_data;
	logic [2:0] o_ch3_oe;
	logic [15:0] hi2, lo2, ed2, hi3, lo3, ed3, e;
	logic [9:0] ra[8] = '{10'h098, 10'h099, 10'h09A, 10'h09B, 10'h198, 10'h196, 10'h197, 10'h2AA};
	logic [7:0] rv[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00};
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	int d0;
	int d3;

	occd_top u_occd_top (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .i_div_in(i_div_in), .i_sync(i_sync), .o_rdata(o_rdata),
		.o_ch2_data(o_ch2_data), .o_ch2_oe(o_ch2_oe), .o_ch3_data(o_ch3_data), .o_ch3_oe(o_ch3_oe));
	occd_rx_model u_occd_rx_model_2 (.i_clock(i_clock), .i_data(o_ch2_data[0]), .i_oe(o_ch2_oe[0]),
		.o_hi_run(hi2), .o_lo_run(lo2), .o_edges(ed2));
	occd_rx_model u_occd_rx_model_3 (.i_clock(i_clock), .i_data(o_ch3_data[0]), .i_oe(o_ch3_oe[0]),
		.o_hi_run(hi3), .o_lo_run(lo3), .o_edges(ed3));

	always #50 i_clock = ~i_clock;
	// input clock at half the system rate, the fastest the divider accepts
	always @(posedge i_clock) i_div_in <= ~i_div_in;

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge i_clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total = err_total + 1;
			end_of_test();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask

	// masked read for fields that move on their own, such as the sampled input
	task automatic rdm(input logic [9:0] a, input logic [7:0] m, input logic [7:0] x);
		@(posedge i_clock);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1;
		chk(16'(o_rdata & m), 16'(x));
	endtask

	task automatic rdc(input logic [9:0] a, input logic [7:0] x);
		rdm(a, 8'hFF, x);
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask

	// sync released at a fixed input phase so two runs compare exactly
	task automatic phase_delay(output int d);
		@(posedge i_clock);
		i_sync <= 1'b1;
		wt(10);
		@(posedge i_clock);
		while (i_div_in !== 1'b1) @(posedge i_clock);
		i_sync <= 1'b0;
		d = 0;
		while (o_ch3_data[0] !== 1'b1 && d < 100)
		begin
			wt(1);
			d++;
		end
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		repeat (20) @(posedge i_clock);
		i_rst <= 1'b0;
		wt(2);
		chk(16'(o_ch2_oe), 16'h7);
		chk(16'(o_ch3_oe), 16'h7);
		for (int k = 0; k < 8; k++) rdc(ra[k], rv[k]);
		wr(10'h2AA, 8'hFF);
		rdc(10'h2AA, 8'h00);
		wr(10'h198, 8'h04);
		wt(3);
		chk(16'(o_ch2_oe), 16'h0);
		chk(16'(o_ch2_data), 16'h0);
		chk(16'(o_ch3_oe), 16'h7);
		wr(10'h09B, 8'hFF);
		rdc(10'h09B, 8'h05);
		chk(16'(o_ch3_oe), 16'h0);
		wr(10'h198, 8'h00);
		wr(10'h09B, 8'h00);
		wt(3);
		chk(16'(o_ch2_oe), 16'h7);
		chk(16'(o_ch3_oe), 16'h7);
		wr(10'h099, 8'h21);
		wr(10'h09B, 8'h01);
		rdc(10'h099, 8'h21);
		wt(40);
		chk(lo3, 16'h6);
		chk(hi3, 16'h4);
		wr(10'h09B, 8'h00);
		wt(40);
		chk(hi3, 16'h6);
		chk(lo3, 16'h4);
		wr(10'h196, 8'h30);
		wt(40);
		chk(hi2, 16'h6);
		chk(lo2, 16'h4);
		wr(10'h098, 8'h01);
		wt(40);
		chk(lo2, 16'h8);
		chk(hi2, 16'h2);
		wr(10'h09A, 8'h80);
		wt(10);
		chk(hi3, 16'h1);
		chk(lo3, 16'h1);
		wr(10'h09A, 8'h10);
		i_sync <= 1'b1;
		wt(10);
		e = ed3;
		chk(16'(o_ch3_data[0]), 16'h1);
		wt(10);
		chk(ed3, e);
		wr(10'h09A, 8'h00);
		wt(6);
		chk(16'(o_ch3_data[0]), 16'h0);
		wr(10'h09A, 8'h40);
		e = ed3;
		wt(20);
		chk(16'(ed3 != e), 16'h1);
		wr(10'h09A, 8'h60);
		wr(10'h09C, 8'h02);
		wt(6);
		chk(16'(o_ch3_data[0]), 16'h1);
		e = ed3;
		wt(10);
		chk(ed3, e);
		wr(10'h09A, 8'h40);
		wt(6);
		chk(16'(o_ch3_data[0]), 16'h0);
		wr(10'h09C, 8'h00);
		wr(10'h099, 8'h00);
		wr(10'h09B, 8'h01);
		wr(10'h09A, 8'h00);
		phase_delay(d0);
		wr(10'h09A, 8'h03);
		rdc(10'h09A, 8'h03);
		phase_delay(d3);
		chk(16'(d3 - d0), 16'h6);
		wr(10'h197, 8'h80);
		wt(10);
		chk(hi2, 16'h1);
		chk(lo2, 16'h1);
		wr(10'h197, 8'h60);
		wr(10'h09A, 8'h60);
		wr(10'h09C, 8'h03);
		rdc(10'h09C, 8'h03);
		wt(4);
		chk(16'(o_ch2_data), 16'h7);
		chk(16'(o_ch3_data), 16'h7);
		rdm(10'h09D, 8'hFB, 8'h03);
		@(posedge i_clock);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		wt(2);
		chk(16'(o_ch2_oe), 16'h7);
		rdc(10'h09C, 8'h00);
		rdc(10'h197, 8'h00);
		rdc(10'h196, 8'h11);
		end_of_test();
	end
endmodule // occd_top_tb
